/* File: inc/mpbc_pkg.sv */
package mpbc_pkg;

  // ***********************************************************
  // register map: printed offsets are word indexes, byte = 4 x index
  // ***********************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] PAUSE_CTRL_IDX = 8'h08;
  localparam logic [ADDR_W-1:0] PAUSE_CTRL_ADDR = {PAUSE_CTRL_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] MODE_CTRL_IDX = 8'h10;
  localparam logic [ADDR_W-1:0] MODE_CTRL_ADDR = {MODE_CTRL_IDX[ADDR_W-3:0], 2'b00};

  // ***********************************************************
  // field positions and reset values
  // ***********************************************************
  localparam int unsigned PT_HI = 31;
  localparam int unsigned PT_LO = 16;
  localparam int unsigned PT_W = 16;
  localparam int unsigned PASS_BIT = 2;
  localparam int unsigned EN_BIT = 1;
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned MODE_FDX_BIT = 0;
  localparam int unsigned MODE_TXEN_BIT = 1;
  localparam int unsigned MODE_SPD100_BIT = 2;
  localparam int unsigned MODE_PROMISC_BIT = 3;
  localparam int unsigned MODE_W = 4;
  localparam logic [31:0] PAUSE_CTRL_RST = 32'h0000_0000;
  localparam logic [MODE_W-1:0] MODE_RST = 4'h0;

  // ***********************************************************
  // timing: one slot is 512 bit times
  // ***********************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SLOT_BITS = 512;
  localparam int unsigned BIT_TIME_NS_100 = 10;
  localparam int unsigned BIT_TIME_NS_10 = 100;
  localparam int unsigned SLOT_CYCLES_100 = SLOT_BITS * BIT_TIME_NS_100 / CLK_PERIOD_NS;
  localparam int unsigned SLOT_CYCLES_10 = SLOT_BITS * BIT_TIME_NS_10 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FC_IDLE,
    FC_SEND,
    FC_BACKPR
  } mpbc_fc_state_type;

endpackage

/* File: verilog/mpbc_pause_timer.sv */
`timescale 1ns/10ps
`default_nettype none

// ***********************************************************
// halt timer: runs for quanta x slot_cycles clocks
// ***********************************************************
module mpbc_pause_timer #(
  parameter int unsigned SLOT_W = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [mpbc_pkg::PT_W-1:0] quanta,
  input wire logic [SLOT_W-1:0] slot_cycles,
  output logic running
);

  logic [mpbc_pkg::PT_W-1:0] quanta_q;
  logic [SLOT_W-1:0] slot_q;
  wire slot_end = (slot_q == '0);
  wire last_quantum = (quanta_q == 16'h0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quanta_q <= '0;
      slot_q <= '0;
      running <= 1'b0;
    end else if (load) begin
      quanta_q <= quanta;
      slot_q <= slot_cycles - 1'b1;
      running <= (quanta != '0);
    end else if (running) begin
      if (slot_end) begin
        quanta_q <= quanta_q - 1'b1;
        slot_q <= slot_cycles - 1'b1;
        running <= !last_quantum;
      end else begin
        slot_q <= slot_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: verilog/mpbc_flow_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none

module mpbc_flow_ctrl #(
  parameter int unsigned SLOT_CYC_100 = mpbc_pkg::SLOT_CYCLES_100,
  parameter int unsigned SLOT_CYC_10 = mpbc_pkg::SLOT_CYCLES_10,
  parameter int unsigned SLOT_W = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mpbc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fc_request,
  output logic pause_frame_req,
  output logic [mpbc_pkg::PT_W-1:0] pause_frame_time,
  input wire logic pause_frame_done,
  output logic backpressure,
  output logic tx_halt,
  input wire logic rx_frame_end,
  input wire logic rx_is_pause,
  input wire logic [mpbc_pkg::PT_W-1:0] rx_pause_quanta,
  input wire logic rx_addr_pass,
  output logic rx_status_valid,
  output logic rx_status_filter
);

  // ***********************************************************
  // elaboration checks
  // ***********************************************************
  if (SLOT_CYC_100 < 1 || SLOT_CYC_10 < 1) begin : g_bad_slot
    $error("slot cycle counts must be at least one");
  end
  if (SLOT_CYC_100 >= (1 << SLOT_W) || SLOT_CYC_10 >= (1 << SLOT_W)) begin : g_bad_width
    $error("slot counter too narrow");
  end

  // ***********************************************************
  // apb slave
  // ***********************************************************
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [mpbc_pkg::PT_W-1:0] pause_time_q;
  logic pass_ctrl_frames_q;
  logic pause_function_enable_q;
  logic [mpbc_pkg::MODE_W-1:0] mode_q;
  logic pause_tx_busy_q;

  wire sel_pause = (paddr == mpbc_pkg::PAUSE_CTRL_ADDR);
  wire sel_mode = (paddr == mpbc_pkg::MODE_CTRL_ADDR);
  wire mapped = sel_pause | sel_mode;
  wire access = psel & penable & ~pready_q;
  wire commit = psel & penable & pready_q;
  wire wr_pause = commit & pwrite & sel_pause;
  wire wr_mode = commit & pwrite & sel_mode;

  wire full_duplex = mode_q[mpbc_pkg::MODE_FDX_BIT];
  wire tx_enable = mode_q[mpbc_pkg::MODE_TXEN_BIT];
  wire speed_100 = mode_q[mpbc_pkg::MODE_SPD100_BIT];
  wire promiscuous = mode_q[mpbc_pkg::MODE_PROMISC_BIT];

  // busy is status only; whatever software writes there is dropped
  wire [31:0] pause_rd = {pause_time_q, 13'h0000, pass_ctrl_frames_q,
                          pause_function_enable_q, pause_tx_busy_q};
  wire [31:0] mode_rd = {28'h000_0000, mode_q};
  wire [31:0] rd_mux = sel_pause ? pause_rd : (sel_mode ? mode_rd : 32'h0000_0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= access;
      pslverr_q <= access & ~mapped;
      prdata_q <= (access & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_time_q <= mpbc_pkg::PAUSE_CTRL_RST[mpbc_pkg::PT_HI:mpbc_pkg::PT_LO];
      pass_ctrl_frames_q <= mpbc_pkg::PAUSE_CTRL_RST[mpbc_pkg::PASS_BIT];
      pause_function_enable_q <= mpbc_pkg::PAUSE_CTRL_RST[mpbc_pkg::EN_BIT];
    end else if (wr_pause) begin
      pause_time_q <= pwdata[mpbc_pkg::PT_HI:mpbc_pkg::PT_LO];
      pass_ctrl_frames_q <= pwdata[mpbc_pkg::PASS_BIT];
      pause_function_enable_q <= pwdata[mpbc_pkg::EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= mpbc_pkg::MODE_RST;
    end else if (wr_mode) begin
      mode_q <= pwdata[mpbc_pkg::MODE_W-1:0];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ***********************************************************
  // transmit side: pause frame and back pressure
  // ***********************************************************
  mpbc_pkg::mpbc_fc_state_type state_q, state_d;
  logic req_prev_q;
  logic pause_frame_req_q;
  logic backpressure_q;
  logic [mpbc_pkg::PT_W-1:0] pause_frame_time_q;

  wire req_rise = fc_request & ~req_prev_q;
  wire start_send = req_rise & tx_enable & full_duplex;
  wire start_bp = fc_request & tx_enable & ~full_duplex & pause_function_enable_q;
  wire stop_bp = ~fc_request | ~tx_enable | full_duplex | ~pause_function_enable_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mpbc_pkg::FC_IDLE: begin
        if (start_send) begin
          state_d = mpbc_pkg::FC_SEND;
        end else if (start_bp) begin
          state_d = mpbc_pkg::FC_BACKPR;
        end
      end
      mpbc_pkg::FC_SEND: begin
        if (pause_frame_done || !tx_enable) begin
          state_d = mpbc_pkg::FC_IDLE;
        end
      end
      mpbc_pkg::FC_BACKPR: begin
        if (stop_bp) begin
          state_d = mpbc_pkg::FC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= mpbc_pkg::FC_IDLE;
      req_prev_q <= 1'b0;
      pause_frame_req_q <= 1'b0;
      backpressure_q <= 1'b0;
      pause_tx_busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_prev_q <= fc_request;
      pause_frame_req_q <= (state_d == mpbc_pkg::FC_SEND);
      backpressure_q <= (state_d == mpbc_pkg::FC_BACKPR);
      pause_tx_busy_q <= (state_d != mpbc_pkg::FC_IDLE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_frame_time_q <= '0;
    end else if (start_send && state_q == mpbc_pkg::FC_IDLE) begin
      pause_frame_time_q <= pause_time_q;
    end
  end

  assign pause_frame_req = pause_frame_req_q;
  assign pause_frame_time = pause_frame_time_q;
  assign backpressure = backpressure_q;

  // ***********************************************************
  // receive side: pause decode, halt timer, status
  // ***********************************************************
  logic rx_status_valid_q;
  logic rx_status_filter_q;

  wire rx_pause_seen = rx_is_pause & pause_function_enable_q;
  wire rx_pause_act = rx_frame_end & rx_pause_seen & full_duplex;
  wire [SLOT_W-1:0] slot_cycles = speed_100 ? SLOT_W'(SLOT_CYC_100) : SLOT_W'(SLOT_CYC_10);
  // promiscuous passes everything; otherwise a pause frame follows the pass bit while pause is enabled, else the address match
  wire filter_d = promiscuous ? 1'b1 :
                  (rx_pause_seen ? pass_ctrl_frames_q : rx_addr_pass);

  mpbc_pause_timer #(
    .SLOT_W(SLOT_W)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(rx_pause_act),
    .quanta(rx_pause_quanta),
    .slot_cycles(slot_cycles),
    .running(tx_halt)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_status_valid_q <= 1'b0;
      rx_status_filter_q <= 1'b0;
    end else begin
      rx_status_valid_q <= rx_frame_end;
      rx_status_filter_q <= rx_frame_end & filter_d;
    end
  end

  assign rx_status_valid = rx_status_valid_q;
  assign rx_status_filter = rx_status_filter_q;

  // ***********************************************************
  // assertions
  // ***********************************************************
  chk_send_needs_txen: assert property (@(posedge pclk) disable iff (!presetn)
    pause_frame_req |-> $past(tx_enable))
    else $error("pause frame requested with transmitter disabled");

  chk_bp_needs_txen: assert property (@(posedge pclk) disable iff (!presetn)
    backpressure |-> $past(tx_enable) && $past(pause_function_enable_q))
    else $error("back pressure without transmitter or enable");

  chk_busy_tracks: assert property (@(posedge pclk) disable iff (!presetn)
    pause_tx_busy_q == (pause_frame_req_q | backpressure_q))
    else $error("busy flag disagrees with activity");

  chk_busy_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == mpbc_pkg::FC_SEND && pause_frame_done) |=> !pause_tx_busy_q)
    else $error("busy not cleared after pause frame sent");

  chk_frame_time: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == mpbc_pkg::FC_IDLE && start_send) |=> pause_frame_time == $past(pause_time_q))
    else $error("pause frame time not taken from register");

  chk_halt_start: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_pause_act && rx_pause_quanta != '0) |=> tx_halt [*2])
    else $error("received pause did not halt transmit");

  chk_no_halt_dis: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_halt && !(rx_frame_end && rx_is_pause && pause_function_enable_q && full_duplex)) |=> !tx_halt)
    else $error("transmit halted without enabled pause");

  chk_filter_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_frame_end && rx_pause_seen && !promiscuous) |=> rx_status_filter == $past(pass_ctrl_frames_q))
    else $error("filter bit does not follow pass bit");

  chk_promisc_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_frame_end && promiscuous) |=> rx_status_filter)
    else $error("promiscuous mode did not override");

  chk_all_delivered: assert property (@(posedge pclk) disable iff (!presetn)
    rx_frame_end |=> rx_status_valid)
    else $error("received frame not delivered");

  chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer not after one wait cycle");

  chk_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood longer than one cycle");

  chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !mapped) |=> pslverr)
    else $error("unmapped access without error response");

  chk_prdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !access |=> prdata == 32'h0000_0000)
    else $error("read data driven outside a read answer");

  chk_apb_write: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && pwrite && sel_pause) |=> pause_time_q == $past(pwdata[mpbc_pkg::PT_HI:mpbc_pkg::PT_LO]))
    else $error("pause time write did not land");

  chk_frame_start: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == mpbc_pkg::FC_IDLE && start_send) |=> pause_frame_req && pause_tx_busy_q)
    else $error("request did not start a pause frame");

  chk_bp_start: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == mpbc_pkg::FC_IDLE && !start_send && start_bp) |=> backpressure && pause_tx_busy_q)
    else $error("request did not start back pressure");

  chk_busy_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == mpbc_pkg::FC_SEND && !pause_frame_done && tx_enable) |=> pause_tx_busy_q && pause_frame_req)
    else $error("busy dropped before pause frame was sent");

  chk_busy_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == mpbc_pkg::FC_IDLE && !start_send && !start_bp) |=> !pause_tx_busy_q)
    else $error("busy set with nothing in progress");

  chk_bp_busy: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == mpbc_pkg::FC_BACKPR && !stop_bp) |=> pause_tx_busy_q && backpressure)
    else $error("busy or back pressure dropped while still asked");

  chk_tx_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !tx_enable |=> !pause_frame_req && !backpressure)
    else $error("flow control active with transmitter disabled");

  chk_frame_time_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == mpbc_pkg::FC_SEND) |=> $stable(pause_frame_time))
    else $error("pause frame time changed during the frame");

  chk_halt_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_pause_act && rx_pause_quanta == '0) |=> !tx_halt)
    else $error("zero pause time did not clear the halt");

  chk_no_act_hdx: assert property (@(posedge pclk) disable iff (!presetn)
    (!full_duplex && !tx_halt) |=> !tx_halt)
    else $error("transmit halted in half duplex");

  chk_addr_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_frame_end && !pause_function_enable_q && !promiscuous) |=> rx_status_filter == $past(rx_addr_pass))
    else $error("pause decoded with enable clear");

  chk_filter_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_frame_end && rx_pause_seen && !promiscuous && !pass_ctrl_frames_q) |=> !rx_status_filter)
    else $error("filter bit set with pass bit clear");

  chk_status_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_frame_end |=> !rx_status_valid && !rx_status_filter)
    else $error("receive status without a frame");

endmodule

`default_nettype wire

/* File: dv/mpbc_tx_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ***********************************************************
// mac transmitter stand-in: sends the pause frame, then pulses done
// ***********************************************************
module mpbc_tx_model (
  input wire logic pclk,
  input wire logic pause_frame_req,
  input wire logic [mpbc_pkg::PT_W-1:0] pause_frame_time,
  input wire logic [7:0] done_delay,
  output var logic pause_frame_done,
  output var logic [mpbc_pkg::PT_W-1:0] sent_time
);
  initial begin
    pause_frame_done = 1'b0;
    sent_time = 16'h0000;
    forever begin
      @(posedge pclk);
      if (pause_frame_req === 1'b1) begin
        sent_time <= pause_frame_time;
        repeat (done_delay) @(posedge pclk);
        // an aborted request gets no done pulse
        if (pause_frame_req === 1'b1) pause_frame_done <= 1'b1;
        @(posedge pclk);
        pause_frame_done <= 1'b0;
        @(posedge pclk);
      end
    end
  end
endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ***********************************************************
  // signals and design
  // ***********************************************************
  localparam int S100 = 2;
  localparam int S10 = 4;
  localparam logic [7:0] A_CTRL = mpbc_pkg::PAUSE_CTRL_ADDR;
  localparam logic [7:0] A_MODE = mpbc_pkg::MODE_CTRL_ADDR;
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] ctl;
    logic ip;
    logic ap;
    logic f;
  } mpbc_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fc_request, pause_frame_req;
  logic pause_frame_done, backpressure, tx_halt, rx_frame_end, rx_is_pause, rx_addr_pass;
  logic rx_status_valid, rx_status_filter;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] pause_frame_time, rx_pause_quanta, sent_time;
  logic e, f;
  int bad_count, n_checks, n;
  mpbc_row_type rows [6];

  mpbc_flow_ctrl #(.SLOT_CYC_100(S100), .SLOT_CYC_10(S10), .SLOT_W(13)) mpbc_flow_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fc_request(fc_request), .pause_frame_req(pause_frame_req), .pause_frame_time(pause_frame_time),
    .pause_frame_done(pause_frame_done), .backpressure(backpressure), .tx_halt(tx_halt),
    .rx_frame_end(rx_frame_end), .rx_is_pause(rx_is_pause), .rx_pause_quanta(rx_pause_quanta),
    .rx_addr_pass(rx_addr_pass), .rx_status_valid(rx_status_valid), .rx_status_filter(rx_status_filter));

  mpbc_tx_model mpbc_tx_model_i (
    .pclk(pclk), .pause_frame_req(pause_frame_req), .pause_frame_time(pause_frame_time),
    .done_delay(8'h14), .pause_frame_done(pause_frame_done), .sent_time(sent_time));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    check(k < 50, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctrl_wr(input logic [31:0] v);
    logic [31:0] rd;
    logic er;
    int k;
    k = 0;
    do begin
      apb(1'b0, A_CTRL, 32'h0000_0000, rd, er);
      k++;
    end while (rd[0] !== 1'b0 && k < 100);
    apb(1'b1, A_CTRL, v & 32'hFFFF_FFFE, rd, er);
  endtask

  task automatic rx_frame(input logic ip, input logic [15:0] q, input logic ap, output logic fo);
    @(posedge pclk);
    rx_is_pause <= ip;
    rx_pause_quanta <= q;
    rx_addr_pass <= ap;
    rx_frame_end <= 1'b1;
    @(posedge pclk);
    rx_frame_end <= 1'b0;
    #1;
    check(rx_status_valid, 1);
    fo = rx_status_filter;
  endtask

  task automatic halt_case(input logic [31:0] mode, input logic [31:0] ctl, input int exp);
    logic fo;
    int k;
    apb(1'b1, A_MODE, mode, r, e);
    ctrl_wr(ctl);
    rx_frame(1'b1, 16'h0003, 1'b0, fo);
    k = 0;
    while (tx_halt === 1'b1 && k < 100) begin
      k++;
      @(posedge pclk);
      #1;
    end
    check(k, exp);
  endtask

  // ***********************************************************
  // watchdog
  // ***********************************************************
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    conclude();
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    {psel, penable, pwrite, fc_request, rx_frame_end, rx_is_pause, rx_addr_pass} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rx_pause_quanta = 16'h0000;
    bad_count = 0;
    n_checks = 0;
    presetn = 1'b0;
    do_reset();
    rows[0] = '{32'h3, 32'h0, 1'b1, 1'b0, 1'b0};
    rows[1] = '{32'h3, 32'h2, 1'b1, 1'b1, 1'b0};
    rows[2] = '{32'h3, 32'h6, 1'b1, 1'b0, 1'b1};
    rows[3] = '{32'hB, 32'h2, 1'b1, 1'b0, 1'b1};
    rows[4] = '{32'h3, 32'h6, 1'b0, 1'b1, 1'b1};
    rows[5] = '{32'h3, 32'h6, 1'b0, 1'b0, 1'b0};
    foreach (rows[i]) begin
      apb(1'b1, A_MODE, rows[i].mode, r, e);
      ctrl_wr(rows[i].ctl);
      rx_frame(rows[i].ip, 16'h0000, rows[i].ap, f);
      check(f, rows[i].f);
    end
    // reset values, field access, unmapped place
    do_reset();
    apb(1'b0, A_CTRL, 32'h0, r, e);
    check(r, mpbc_pkg::PAUSE_CTRL_RST);
    apb(1'b0, 8'h24, 32'h0, r, e);
    check(r, 32'h0000_0000);
    check(e, 1);
    ctrl_wr(32'hFFFF_FFFF);
    apb(1'b0, A_CTRL, 32'h0, r, e);
    check(r, 32'hFFFF_0006);
    do_reset();
    apb(1'b0, A_CTRL, 32'h0, r, e);
    check(r, 32'h0000_0000);
    // pause frame in full duplex
    ctrl_wr(32'hA5C3_0000);
    apb(1'b1, A_MODE, 32'h3, r, e);
    @(posedge pclk);
    fc_request <= 1'b1;
    @(posedge pclk);
    #1;
    check(pause_frame_req, 1);
    check(pause_frame_time, 16'hA5C3);
    apb(1'b0, A_CTRL, 32'h0, r, e);
    check(r[0], 1);
    n = 0;
    while (pause_frame_req === 1'b1 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    check(sent_time, 16'hA5C3);
    apb(1'b0, A_CTRL, 32'h0, r, e);
    check(r[0], 0);
    fc_request <= 1'b0;
    // transmitter disabled
    apb(1'b1, A_MODE, 32'h1, r, e);
    fc_request <= 1'b1;
    repeat (4) @(posedge pclk);
    check(pause_frame_req, 0);
    fc_request <= 1'b0;
    ctrl_wr(32'h2);
    apb(1'b1, A_MODE, 32'h0, r, e);
    fc_request <= 1'b1;
    repeat (4) @(posedge pclk);
    check(backpressure, 0);
    fc_request <= 1'b0;
    // back pressure in half duplex
    apb(1'b1, A_MODE, 32'h2, r, e);
    fc_request <= 1'b1;
    @(posedge pclk);
    #1;
    check(backpressure, 1);
    apb(1'b0, A_CTRL, 32'h0, r, e);
    check(r[0], 1);
    fc_request <= 1'b0;
    repeat (2) @(posedge pclk);
    check(backpressure, 0);
    ctrl_wr(32'h0);
    fc_request <= 1'b1;
    repeat (3) @(posedge pclk);
    check(backpressure, 0);
    fc_request <= 1'b0;
    // received pause halts the transmitter only in full duplex with pause enabled
    halt_case(32'h7, 32'h2, 3 * S100);
    halt_case(32'h3, 32'h2, 3 * S10);
    halt_case(32'h7, 32'h0, 0);
    halt_case(32'h6, 32'h2, 0);
    conclude();
  end
endmodule

`default_nettype wire
